// >>> serial_cs_cfg.svh
`ifndef SERIAL_CS_CFG_SVH
`define SERIAL_CS_CFG_SVH
// register byte offsets on the wishbone bus
`define OFS_CONTROL 4'h0
`define OFS_STATUS 4'h4
`define OFS_MODE 4'h8
`define OFS_PIN 4'hc
// rx data register: read pops the receive fifo head
`define OFS_RX_DATA 4'h0
`define OFS_RX_DATA_HI 1'b1
// serial control fields
`define CTL_SRC_BIT 1
`define CTL_OE_BIT 0
`define CTL_RSVD_BIT 2
`define CTL_RX_EN_BIT 4
`define CTL_RESET 16'h0000
`define CTL_WMASK 16'h00fb
// serial mode fields
`define MODE_SYNC_BIT 7
`define MODE_PAR_EN_BIT 5
`define MODE_ODD_BIT 4
`define MODE_TWO_STOP_BIT 3
`define MODE_RESET 8'h00
// status fields
`define ST_RESET 16'h0060
`define ST_ER 7
`define ST_TRANSMIT_END_FLAG 6
`define ST_TRANSMIT_FIFO_EMPTY_FLAG 5
`define ST_BRK 4
`define ST_FER 3
`define ST_PER 2
`define ST_RDF 1
`define ST_DR 0
`define ST_CLEARABLE 8'hf3
// receive fifo
`define FIFO_DEPTH 16
`define RDF_TRIGGER 5'd8
// 16x tick from clk_i: 250 MHz / (2 * 8) gives a 15.625 MHz sampling clock
`define HALF_DIV 8'd7
`define OVERSAMPLE 5'd16
`define MID_SAMPLE 5'd7
`endif

// >>> serial_cs_pkg.sv
package serial_cs_pkg;
	typedef enum logic [2:0] {
		RX_IDLE = 3'b000,
		RX_START = 3'b001,
		RX_DATA = 3'b011,
		RX_PARITY = 3'b010,
		RX_STOP = 3'b110
	} rx_state_e;
	typedef struct packed {
		logic parity_err;
		logic framing_err;
		logic [7:0] data;
	} rx_entry_s;
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [3:0] sel;
		logic [3:0] adr;
		logic [31:0] dat;
	} wb_req_s;
endpackage : serial_cs_pkg

// >>> serial_clock_status.sv
`timescale 1ns/100ps
`include "serial_cs_cfg.svh"
// What this block does
// - control bit 2 always reads zero
// - output enable honoured only with internal source
// - async 00: internal clock, pin from direction/level
// - async 01: drive pin at sixteen times rate
// - async external: pin clock is sixteen-times clock
// - sync 00/01: internal clock driven out on pin
// - sync 10: shift on clock received from pin
// - status sixteen bits: counts high, flags low
// - flags cleared by zero only after read-as-one
// - head framing/parity bits are read-only
// - reset loads status with 0060
// - bits 15..12 parity error count, sixteen reads zero
// - bits 11..8 framing error count, sixteen reads zero
// - errored characters still stored and tagged
// - only first stop bit checked
module serial_clock_status
	import serial_cs_pkg::*;
(
	// system
	input wire logic clk_i,
	input wire logic reset_n_i,
	// classic wishbone slave
	input wire wb_req_s wb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// serial clock pin, link clock port and receive line
	input wire logic sck_clk_i,
	output logic sck_o,
	output logic sck_oe_n_o,
	input wire logic rxd_i,
	// transmitter events from the shifter outside
	input wire logic tx_end_evt_i,
	input wire logic tx_fifo_empty_evt_i
);
	// registers
	logic [15:0] control_r;
	logic [7:0] mode_r;
	logic clock_pin_direction_r;
	logic clock_pin_level_r;
	logic [7:0] flags_r;
	logic [7:0] seen_r;
	logic ack_r;
	logic [31:0] rdat_r;
	logic sck_r;
	logic sck_oe_n_r;
	// link side
	logic link_rst_meta_r;
	logic link_rst_n_r;
	logic link_tgl_r;
	logic [2:0] tick_sync_r;
	// rx line synchroniser
	logic [2:0] rxd_sync_r;
	logic rxd_r;
	// internal divider
	logic [7:0] div_r;
	logic int_half;
	logic int_clk_r;
	logic int_tick;
	logic [2:0] sync_div_r;
	// receiver
	rx_state_e rx_state_r;
	logic [4:0] os_cnt_r;
	logic [2:0] bit_cnt_r;
	logic [7:0] shift_r;
	logic par_bad_r;
	// fifo
	rx_entry_s fifo_r [0:`FIFO_DEPTH-1];
	logic [3:0] wr_ptr_r;
	logic [3:0] rd_ptr_r;
	logic [4:0] count_r;
	// combinational
	logic access;
	logic wr_en;
	logic rd_en;
	logic ext_src;
	logic sync_mode;
	logic tick;
	logic [4:0] os_len;
	logic [4:0] os_mid;
	logic push;
	logic pop;
	logic fe;
	logic pe;
	logic line_break_flag;
	rx_entry_s head;
	logic [4:0] per_cnt;
	logic [4:0] fer_cnt;
	logic [15:0] status;
	logic sck_nxt;
	logic sck_oe_n_nxt;
	logic [7:0] flags_nxt;
	logic [7:0] seen_nxt;
	logic [7:0] set_ev;
	logic [7:0] clr_ev;

	// bus decode
	assign access = wb_i.cyc & wb_i.stb & ~ack_r;
	assign wr_en = wb_i.cyc & wb_i.stb & wb_i.we & ack_r; // lands on the edge at which the master sees ack
	assign rd_en = access & ~wb_i.we;
	assign ext_src = control_r[`CTL_SRC_BIT]; // 1x and 11 both external
	assign sync_mode = mode_r[`MODE_SYNC_BIT];

	// one-cycle ack, dropped in the cycle after it was given
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= access;
		end
	end

	// control register; reserved bit 2 is never stored
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			control_r <= `CTL_RESET;
		end else if (wr_en && wb_i.adr == `OFS_CONTROL) begin
			if (wb_i.sel[0]) begin
				control_r[7:0] <= wb_i.dat[7:0] & 8'(`CTL_WMASK);
			end
		end
	end

	// mode and pin registers
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			mode_r <= `MODE_RESET;
			clock_pin_direction_r <= 1'b0;
			clock_pin_level_r <= 1'b0;
		end else if (wr_en && wb_i.sel[0]) begin
			if (wb_i.adr == `OFS_MODE) begin
				mode_r <= wb_i.dat[7:0];
			end
			if (wb_i.adr == `OFS_PIN) begin
				clock_pin_direction_r <= wb_i.dat[1];
				clock_pin_level_r <= wb_i.dat[0];
			end
		end
	end

	// link domain reset: two flops, the clock may stand still between frames
	always_ff @(posedge sck_clk_i) begin
		link_rst_meta_r <= reset_n_i;
		link_rst_n_r <= link_rst_meta_r;
	end

	// one toggle per rising external clock edge, carried over as an event
	always_ff @(posedge sck_clk_i) begin
		if (!link_rst_n_r) begin
			link_tgl_r <= 1'b0;
		end else begin
			link_tgl_r <= ~link_tgl_r;
		end
	end

	// toggle crossing: first flop feeds only the second
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			tick_sync_r <= 3'h0;
		end else begin
			tick_sync_r <= {tick_sync_r[1:0], link_tgl_r};
		end
	end

	// rx line: three flops, a change counts once stages two and three agree
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			rxd_sync_r <= 3'h7;
			rxd_r <= 1'b1;
		end else begin
			rxd_sync_r <= {rxd_sync_r[1:0], rxd_i};
			if (rxd_sync_r[1] == rxd_sync_r[2]) begin
				rxd_r <= rxd_sync_r[2];
			end
		end
	end

	// internal 16x clock from a half-period divider
	assign int_half = (div_r == `HALF_DIV);
	assign int_tick = int_half & ~int_clk_r;
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			div_r <= 8'h00;
			int_clk_r <= 1'b0;
			sync_div_r <= 3'h0;
		end else begin
			div_r <= int_half ? 8'h00 : div_r + 8'h01;
			if (int_half) begin
				int_clk_r <= ~int_clk_r;
			end
			if (int_tick) begin
				sync_div_r <= sync_div_r + 3'h1;
			end
		end
	end

	// sampling tick: pin clock when external, else the internal divider
	assign tick = ext_src ? (tick_sync_r[2] ^ tick_sync_r[1]) : int_tick;
	// async oversamples 16x; sync takes one sample per tick, received clock or internal 16x tick
	assign os_len = sync_mode ? 5'd1 : `OVERSAMPLE;
	assign os_mid = sync_mode ? 5'd0 : `MID_SAMPLE;

	// pin drive; enable is active low
	always_comb begin
		sck_nxt = 1'b0;
		sck_oe_n_nxt = 1'b1;
		if (!ext_src) begin
			if (sync_mode) begin
				sck_nxt = sync_div_r[2]; // bit clock is 16x clock over eight toggles
				sck_oe_n_nxt = 1'b0;
			end else if (control_r[`CTL_OE_BIT]) begin
				sck_nxt = int_clk_r;
				sck_oe_n_nxt = 1'b0;
			end else begin
				sck_nxt = clock_pin_level_r;
				sck_oe_n_nxt = ~clock_pin_direction_r;
			end
		end
	end

	// registered pin outputs
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			sck_r <= 1'b0;
			sck_oe_n_r <= 1'b1;
		end else begin
			sck_r <= sck_nxt;
			sck_oe_n_r <= sck_oe_n_nxt;
		end
	end

	// receiver: mode must be settled before select bits change, nothing retimes it
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			rx_state_r <= RX_IDLE;
			os_cnt_r <= 5'h00;
			bit_cnt_r <= 3'h0;
			shift_r <= 8'h00;
			par_bad_r <= 1'b0;
		end else if (!control_r[`CTL_RX_EN_BIT]) begin
			rx_state_r <= RX_IDLE;
		end else if (tick) begin
			os_cnt_r <= (os_cnt_r == os_len - 5'd1) ? 5'h00 : os_cnt_r + 5'h01;
			case (rx_state_r)
				RX_IDLE: begin
					os_cnt_r <= 5'h00;
					bit_cnt_r <= 3'h0;
					par_bad_r <= mode_r[`MODE_ODD_BIT];
					if (!rxd_r) begin
						rx_state_r <= sync_mode ? RX_DATA : RX_START; // sync: the next tick is data bit 0
					end
				end
				RX_START: begin
					if (os_cnt_r == os_mid) begin
						os_cnt_r <= 5'h00;
						rx_state_r <= rxd_r ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (os_cnt_r == os_len - 5'd1) begin
						shift_r <= {rxd_r, shift_r[7:1]};
						par_bad_r <= par_bad_r ^ rxd_r;
						bit_cnt_r <= bit_cnt_r + 3'h1;
						if (bit_cnt_r == 3'h7) begin
							rx_state_r <= mode_r[`MODE_PAR_EN_BIT] ? RX_PARITY : RX_STOP;
						end
					end
				end
				RX_PARITY: begin
					if (os_cnt_r == os_len - 5'd1) begin
						par_bad_r <= par_bad_r ^ rxd_r;
						rx_state_r <= RX_STOP;
					end
				end
				RX_STOP: begin
					// second stop bit passes as idle line, never checked
					if (os_cnt_r == os_len - 5'd1) begin
						rx_state_r <= RX_IDLE;
					end
				end
				default: begin
					rx_state_r <= RX_IDLE;
				end
			endcase
		end
	end

	// character done at the first stop sample
	assign push = control_r[`CTL_RX_EN_BIT] & tick & (rx_state_r == RX_STOP) & (os_cnt_r == os_len - 5'd1);
	assign fe = ~rxd_r;
	assign pe = mode_r[`MODE_PAR_EN_BIT] & par_bad_r;
	assign line_break_flag = fe & (shift_r == 8'h00);
	assign head = fifo_r[rd_ptr_r];
	assign pop = rd_en & (wb_i.adr == `OFS_RX_DATA) & wb_i.adr[3] == 1'b0 & (count_r != 5'h00)
		& wb_i.sel[1] == `OFS_RX_DATA_HI;

	// fifo storage; a character arriving when full is dropped
	always_ff @(posedge clk_i) begin
		if (push && count_r != 5'd16) begin
			fifo_r[wr_ptr_r] <= '{parity_err: pe, framing_err: fe, data: shift_r};
		end
	end

	// fifo pointers and fill level
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			wr_ptr_r <= 4'h0;
			rd_ptr_r <= 4'h0;
			count_r <= 5'h00;
		end else begin
			if (push && count_r != 5'd16) begin
				wr_ptr_r <= wr_ptr_r + 4'h1;
			end
			if (pop) begin
				rd_ptr_r <= rd_ptr_r + 4'h1;
			end
			count_r <= count_r + {4'h0, push && count_r != 5'd16} - {4'h0, pop};
		end
	end

	// error counts over the valid entries; only low four bits reach software
	always_comb begin
		per_cnt = 5'h00;
		fer_cnt = 5'h00;
		for (int i = 0; i < `FIFO_DEPTH; i++) begin
			if (5'(i) < count_r) begin
				per_cnt = per_cnt + {4'h0, fifo_r[4'(rd_ptr_r + 4'(i))].parity_err};
				fer_cnt = fer_cnt + {4'h0, fifo_r[4'(rd_ptr_r + 4'(i))].framing_err};
			end
		end
	end

	// status view; counts of sixteen wrap to zero
	assign status = {per_cnt[3:0], fer_cnt[3:0], flags_r[7:4],
		(count_r != 5'h00) & head.framing_err, (count_r != 5'h00) & head.parity_err, flags_r[1:0]};

	// hardware set events
	always_comb begin
		set_ev = 8'h00;
		set_ev[`ST_ER] = push & (fe | pe);
		set_ev[`ST_TRANSMIT_END_FLAG] = tx_end_evt_i;
		set_ev[`ST_TRANSMIT_FIFO_EMPTY_FLAG] = tx_fifo_empty_evt_i;
		set_ev[`ST_BRK] = push & line_break_flag;
		set_ev[`ST_RDF] = push & (count_r + 5'd1 >= `RDF_TRIGGER);
		set_ev[`ST_DR] = push;
	end

	// clear only where software wrote zero over a flag it saw set
	assign clr_ev = (wr_en && wb_i.adr == `OFS_STATUS && wb_i.sel[0]) ?
		(seen_r & ~wb_i.dat[7:0] & `ST_CLEARABLE) : 8'h00;

	// flags: set wins over clear, writes never set
	always_comb begin
		flags_nxt = (flags_r & ~clr_ev) | set_ev;
		seen_nxt = seen_r & ~clr_ev;
		if (rd_en && wb_i.adr == `OFS_STATUS) begin
			seen_nxt = seen_nxt | flags_r;
		end
	end

	// status flag register
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			flags_r <= 8'(`ST_RESET);
			seen_r <= 8'h00;
		end else begin
			flags_r <= flags_nxt & `ST_CLEARABLE;
			seen_r <= seen_nxt & `ST_CLEARABLE;
		end
	end

	// read data, registered with the ack; unmapped reads return zero
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			rdat_r <= 32'h0000_0000;
		end else if (rd_en) begin
			case (wb_i.adr)
				`OFS_CONTROL: rdat_r <= {16'h0000, control_r};
				`OFS_STATUS: rdat_r <= {16'h0000, status};
				`OFS_MODE: rdat_r <= {24'h000000, mode_r};
				`OFS_PIN: rdat_r <= {30'h0, clock_pin_direction_r, clock_pin_level_r};
				default: rdat_r <= 32'h0000_0000;
			endcase
		end
	end

	assign wb_dat_o = rdat_r;
	assign wb_ack_o = ack_r;
	assign sck_o = sck_r;
	assign sck_oe_n_o = sck_oe_n_r;
endmodule : serial_clock_status

// >>> serial_peer.sv
`timescale 1ns/100ps
module serial_peer (
	// link clock and line toward the device
	output logic sck_o,
	output logic rxd_o
);
	// line idles at mark, clock stands still between frames
	initial begin
		sck_o = 1'b0;
		rxd_o = 1'b1;
	end
	// one 64 ns period per tick
	task automatic tick(input int n);
		repeat (n) begin
			#32 sck_o = 1'b1;
			#32 sck_o = 1'b0;
		end
	endtask : tick
	// data moves while the clock is low
	// sixteen ticks a bit in async, one tick a bit in sync
	task automatic bit_out(input logic v, input int n);
		rxd_o = v;
		tick(n);
	endtask : bit_out
	// start, lsb first, optional parity, two stop slots
	task automatic send(input logic [7:0] d, input logic pen, input logic p, input logic s1, input logic s2,
		input int n);
		bit_out(1'b0, n);
		for (int i = 0; i < 8; i++) bit_out(d[i], n);
		if (pen) bit_out(p, n);
		bit_out(s1, n);
		bit_out(s2, n);
		rxd_o = 1'b1;
	endtask : send
endmodule : serial_peer

// >>> serial_clock_status_chk.sv
`timescale 1ns/100ps
module serial_clock_status_chk
	import serial_cs_pkg::*;
(
	// clocks and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic sck_clk_i,
	// bus and pin
	input wire wb_req_s wb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic sck_o,
	input wire logic sck_oe_n_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	logic [7:0] ctl_r;
	logic [7:0] mode_r;
	logic [7:0] pin_r;
	logic rd_ack;
	logic m16;
	assign rd_ack = wb_ack_o && !wb_i.we;
	assign m16 = !mode_r[7] && ctl_r[1:0] == 2'b01;
	// shadow copies taken at the acknowledged write
	always_ff @(posedge clk_i) begin
		if (!reset_n_i) begin
			ctl_r <= 8'h00;
			mode_r <= 8'h00;
			pin_r <= 8'h00;
		end else if (wb_ack_o && wb_i.we && wb_i.sel[0]) begin
			if (wb_i.adr == 4'h0) ctl_r <= wb_i.dat[7:0];
			if (wb_i.adr == 4'h8) mode_r <= wb_i.dat[7:0];
			if (wb_i.adr == 4'hc) pin_r <= wb_i.dat[7:0];
		end
	end
	// pins trail the shadow by a cycle, so each check waits for a settled window
	sequence s_pin_io;
		(!mode_r[7] && ctl_r[1:0] == 2'b00 && $stable(pin_r)) [*3];
	endsequence
	sequence s_drive;
		(!ctl_r[1] && (ctl_r[0] || mode_r[7])) [*3];
	endsequence
	sequence s_clk16;
		m16 [*4] ##0 $changed(sck_o);
	endsequence
	ack_next_a: assert property (wb_i.cyc && wb_i.stb && !wb_ack_o |=> wb_ack_o)
		else $error("ack missing one cycle after request");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	rsvd_zero_a: assert property (rd_ack && wb_i.adr == 4'h0 |-> !wb_dat_o[2])
		else $error("reserved control bit read as one");
	data_width_a: assert property (rd_ack |-> wb_dat_o[31:16] == 16'h0000)
		else $error("read data above bit 15");
	unmapped_zero_a: assert property (rd_ack && wb_i.adr[1:0] != 2'b00 |-> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	ext_release_a: assert property (ctl_r[1] [*3] |-> sck_oe_n_o)
		else $error("pin driven with external source");
	int_drive_a: assert property (s_drive |-> !sck_oe_n_o)
		else $error("pin not driven with internal clock out");
	pin_follow_a: assert property (s_pin_io |-> sck_oe_n_o != pin_r[1] && sck_o == pin_r[0])
		else $error("pin not following direction and level");
	clk16_rate_a: assert property (s_clk16 |=> ($stable(sck_o) || !m16) [*7] ##1 ($changed(sck_o) || !m16))
		else $error("pin clock half period not 8 cycles");
endmodule : serial_clock_status_chk
bind serial_clock_status serial_clock_status_chk i_serial_clock_status_chk (.clk_i, .reset_n_i, .sck_clk_i, .wb_i,
	.wb_dat_o, .wb_ack_o, .sck_o, .sck_oe_n_o);

// >>> serial_clock_status_tb_top.sv
`timescale 1ns/100ps
module serial_clock_status_tb_top;
	import serial_cs_pkg::*;
	logic clk_i, reset_n_i, tx_end_evt_i, tx_fifo_empty_evt_i;
	logic sck_o, sck_oe_n_o, wb_ack_o, pk, rx, pin_w;
	wb_req_s wb_i;
	logic [31:0] wb_dat_o, q;
	int err_count, n_compared;
	// the pin wire: device wins while enabled, else the peer's clock
	assign pin_w = sck_oe_n_o ? pk : sck_o;
	serial_peer i_serial_peer (.sck_o(pk), .rxd_o(rx));
	serial_clock_status i_serial_clock_status (.clk_i(clk_i), .reset_n_i(reset_n_i), .wb_i(wb_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sck_clk_i(pin_w), .sck_o(sck_o), .sck_oe_n_o(sck_oe_n_o),
		.rxd_i(rx), .tx_end_evt_i(tx_end_evt_i), .tx_fifo_empty_evt_i(tx_fifo_empty_evt_i));
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	task automatic summarize;
		$display("compared %0d errors %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : summarize
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s exp %h got %h", s, e, g);
		end
	endtask : chk
	// one classic cycle, held until ack is sampled
	task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
		wb_i <= '{1'b1, 1'b1, w, 4'hf, a, {16'h0000, d}};
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_i.cyc <= 1'b0;
		wb_i.stb <= 1'b0;
		@(posedge clk_i);
	endtask : bus
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
		bus(1'b0, a, 16'h0000);
		chk(s, e, q & m);
	endtask : rd
	// mode goes in before the clock select
	task automatic pin(input logic [7:0] m, input logic [7:0] c, input logic [1:0] p, input logic oe);
		wr(4'h8, {8'h00, m});
		wr(4'h0, {8'h00, c});
		wr(4'hc, {14'h0, p});
		repeat (20) @(posedge clk_i);
		chk("pin oe_n", {31'h0, oe}, {31'h0, sck_oe_n_o});
	endtask : pin
	task automatic rxc(input logic [7:0] d, input logic pen, input logic p, input logic s1, input logic s2,
		input int n = 16);
		i_serial_peer.send(d, pen, p, s1, s2, n);
		repeat (20) @(posedge clk_i);
	endtask : rxc
	// link domain reset needs link edges as well
	task automatic rst;
		reset_n_i <= 1'b0;
		i_serial_peer.tick(2);
		repeat (8) @(posedge clk_i);
		reset_n_i <= 1'b1;
		@(posedge clk_i);
	endtask : rst
	initial begin
		repeat (100000) @(posedge clk_i);
		err_count++;
		summarize();
	end
	initial begin
		wb_i = '0;
		reset_n_i = 1'b0;
		tx_end_evt_i = 1'b0;
		tx_fifo_empty_evt_i = 1'b0;
		err_count = 0;
		n_compared = 0;
		rst();
		wr(4'h4, 16'h0000);
		rd(4'h4, 32'hffffffff, 32'h60, "status unread");
		wr(4'h4, 16'h0000);
		rd(4'h4, 32'hffffffff, 32'h0, "status cleared");
		wr(4'h4, 16'hffff);
		rd(4'h4, 32'hffffffff, 32'h0, "status no set");
		tx_end_evt_i <= 1'b1;
		tx_fifo_empty_evt_i <= 1'b1;
		@(posedge clk_i);
		tx_end_evt_i <= 1'b0;
		tx_fifo_empty_evt_i <= 1'b0;
		rd(4'h4, 32'hffffffff, 32'h60, "tx flags");
		wr(4'h0, 16'hffff);
		rd(4'h0, 32'hffffffff, 32'hfb, "control");
		rd(4'h2, 32'hffffffff, 32'h0, "unmapped");
		pin(8'h00, 8'h00, 2'h3, 1'b0);
		chk("pin level", 32'h1, {31'h0, sck_o});
		pin(8'h00, 8'h00, 2'h1, 1'b1);
		pin(8'h00, 8'h01, 2'h0, 1'b0);
		pin(8'h00, 8'h03, 2'h3, 1'b1);
		pin(8'h00, 8'h02, 2'h3, 1'b1);
		pin(8'h80, 8'h00, 2'h0, 1'b0);
		pin(8'h80, 8'h01, 2'h0, 1'b0);
		pin(8'h80, 8'h02, 2'h0, 1'b1);
		pin(8'h80, 8'h03, 2'h3, 1'b1);
		wr(4'h8, 16'h0080);
		wr(4'h0, 16'h0012);
		rxc(8'h55, 1'b0, 1'b0, 1'b1, 1'b1, 1);
		rd(4'h4, 32'hffffffff, 32'h0061, "sync char");
		wr(4'h4, 16'h0000);
		wr(4'h8, 16'h0000);
		wr(4'h0, 16'h0012);
		rxc(8'h55, 1'b0, 1'b0, 1'b1, 1'b1);
		rd(4'h4, 32'hff01, 32'h0001, "good char");
		rxc(8'h55, 1'b0, 1'b0, 1'b0, 1'b1);
		rd(4'h4, 32'hff80, 32'h0180, "framing");
		wr(4'h8, 16'h0020);
		rxc(8'h55, 1'b1, 1'b1, 1'b1, 1'b1);
		rd(4'h4, 32'hff00, 32'h1100, "parity");
		wr(4'h8, 16'h0028);
		rxc(8'h55, 1'b1, 1'b0, 1'b1, 1'b0);
		rd(4'h4, 32'hff00, 32'h1100, "second stop");
		rst();
		wr(4'h8, 16'h0020);
		wr(4'h0, 16'h0012);
		for (int i = 0; i < 15; i++) rxc(8'ha5, 1'b1, 1'b1, 1'b0, 1'b1);
		rd(4'h4, 32'hffffffff, 32'hffef, "fifteen errors");
		rxc(8'ha5, 1'b1, 1'b1, 1'b0, 1'b1);
		rd(4'h4, 32'hffffffff, 32'h00ef, "sixteen errors");
		summarize();
	end
endmodule : serial_clock_status_tb_top
